// [rtl/rpf_framer.sv]
`timescale 1ns/1ps
module rpf_framer (
    input  wire logic        sys_clk,
    input  wire logic        rst_b,
    input  wire logic [8:0]  reg_addr,
    input  wire logic        reg_wr,
    input  wire logic [7:0]  reg_wdata,
    output logic      [7:0]  reg_rdata,
    input  wire logic [23:0] sync_pattern,
    input  wire logic        tx_start,
    input  wire logic [7:0]  tx_data,
    input  wire logic        tx_valid,
    input  wire logic        tx_last,
    output logic             tx_ready,
    output logic             tx_chip,
    output logic             tx_chip_valid,
    input  wire logic        tx_chip_ready,
    input  wire logic        rx_enable,
    input  wire logic        rx_chip,
    input  wire logic        rx_chip_valid,
    output logic      [7:0]  rx_data,
    output logic             rx_data_valid,
    output logic             preamble_seen,
    output logic             sync_seen,
    output logic             crc_ok,
    output logic             pa_ctl_pin_a,
    output logic             lna_ctl_pin_a,
    output logic             pa_ctl_pin_b,
    output logic             lna_ctl_pin_b
);
    import rpf_pkg::*;

    rpf_state_type s_reg;
    rpf_state_type s_next;

    logic        man;
    logic        dcb;
    logic        wht;
    logic        sel;
    logic        sym10;
    logic [3:0]  thr;
    logic [1:0]  tol;
    logic [4:0]  lc;
    logic [1:0]  nsync;
    logic [15:0] poly;
    logic [4:0]  nbw;
    logic [4:0]  need;
    logic [23:0] sw;
    logic [23:0] mask;
    logic [23:0] rw;
    logic [11:0] pe;
    logic [4:0]  perr;
    logic        pre_ok;
    logic [2:0]  ri;
    logic [4:0]  c;
    logic        enc;
    logic        ecrc;
    logic [7:0]  eb;
    logic [7:0]  w;
    logic [4:0]  wp;
    logic [9:0]  code;
    logic [16:0] pm;
    logic [1:0]  si;
    logic [19:0] v;
    logic [9:0]  rcode;
    logic [7:0]  rw8;
    logic [16:0] pm2;
    logic [7:0]  rb;

    // Ones count, shared by balance, sync and preamble checks
    function automatic logic [4:0] pop24(input logic [23:0] x);
        logic [4:0] p;
        p = 5'h00;
        for (int i = 0; i < 24; i++) begin
            p = p + {4'h0, x[i]};
        end
        return p;
    endfunction : pop24

    // Eight steps of x^9+x^5+1, returns next state and mask, first bit at mask[7]
    function automatic logic [16:0] pn8(input logic [8:0] l);
        logic [8:0] t;
        logic [7:0] m;
        t = l;
        m = 8'h00;
        for (int i = 7; i >= 0; i--) begin
            m[i] = t[0];
            t = {t[0] ^ t[5], t[8:1]};
        end
        return {t, m};
    endfunction : pn8

    // Serial CRC over one byte, MSB first
    function automatic logic [15:0] crc8(input logic [15:0] cr, input logic [7:0] b,
                                         input logic [15:0] p);
        logic [15:0] t;
        logic        f;
        t = cr;
        for (int i = 7; i >= 0; i--) begin
            f = t[15] ^ b[i];
            t = {t[14:0], 1'b0};
            if (f) begin
                t = t ^ p;
            end
        end
        return t;
    endfunction : crc8

    // One becomes chips 10, zero becomes 01
    function automatic logic [19:0] man_exp(input logic [9:0] x);
        logic [19:0] o;
        o = 20'h00000;
        for (int i = 0; i < 10; i++) begin
            o[2*i +: 2] = x[i] ? 2'b10 : 2'b01;
        end
        return o;
    endfunction : man_exp

    // First chip of each pair carries the bit
    function automatic logic [9:0] man_dec(input logic [19:0] x);
        logic [9:0] o;
        o = 10'h000;
        for (int i = 0; i < 10; i++) begin
            o[i] = x[2*i+1];
        end
        return o;
    endfunction : man_dec

    // Register address to storage index
    function automatic logic [2:0] reg_idx(input logic [8:0] a);
        logic [8:0] d;
        d = a - ADDR_PQ;
        return (a >= ADDR_PQ && a <= ADDR_SW) ? d[2:0] : IDX_NONE;
    endfunction : reg_idx

    // Live configuration; changes take effect from the cycle after the write
    assign man   = s_reg.cfg[IDX_SC][MAN_ON];
    assign dcb   = s_reg.cfg[IDX_SC][DCB_ON];
    assign wht   = s_reg.cfg[IDX_SC][WHT_ON];
    assign sym10 = s_reg.cfg[IDX_SC][SYM_MSB:0] == SYM_10;   // RULE5
    assign sel   = s_reg.cfg[IDX_PQ][PIN_SEL];
    assign thr   = s_reg.cfg[IDX_PQ][THR_MSB:0];
    assign tol   = s_reg.cfg[IDX_SW][TOL_MSB:TOL_LSB];
    assign poly  = s_reg.cfg[IDX_SC][CRC_ON] ?                  // RULE7
                   {s_reg.cfg[IDX_CH], s_reg.cfg[IDX_CL]} : CRC_DEF;

    // Sync length clamped at 24 bits, rounded up to whole bytes
    assign lc    = (s_reg.cfg[IDX_SW][LEN_MSB:0] > SYNC_MAX) ?
                   SYNC_MAX : s_reg.cfg[IDX_SW][LEN_MSB:0];      // RULE9
    assign nsync = 2'((lc + 5'h07) >> 3);                        // RULE10

    // Symbol size in bits and in chips
    assign nbw   = (dcb || sym10) ? BITS_10 : BITS_8;           // RULE5
    assign need  = man ? {nbw[3:0], 1'b0} : nbw;

    // Air order of the sync bytes, last bit at position 0
    assign sw    = {sync_pattern[7:0], sync_pattern[15:8], sync_pattern[23:16]};
    assign mask  = (24'h000001 << lc) - 24'h000001;
    assign rw    = {s_reg.win[22:0], rx_chip};

    // Bit pairs of the window that break the alternating preamble
    genvar k;
    generate
        for (k = 0; k < 12; k++) begin : g_pair
            assign pe[k] = ~(rw[2*k] ^ rw[2*k+1]);
        end
    endgenerate
    assign perr   = pop24({12'h000, pe});
    assign pre_ok = thr != 4'h0 && thr <= PAIRS &&
                    perr <= {1'b0, PAIRS - thr};                // RULE1

    // Next state of registers, transmitter and receiver
    always_comb begin
        s_next = s_reg;
        ri     = reg_idx(reg_addr);
        c      = s_reg.cnt;
        enc    = 1'b0;
        ecrc   = 1'b0;
        eb     = 8'h00;
        w      = 8'h00;
        wp     = 5'h00;
        code   = 10'h000;
        pm     = 17'h00000;
        si     = 2'h3 - s_reg.bcnt[1:0];
        v      = 20'h00000;
        rcode  = 10'h000;
        rw8    = 8'h00;
        pm2    = 17'h00000;
        rb     = 8'h00;

        // Register port; read data shows the value before a same-cycle write
        s_next.rdata = (ri == IDX_NONE) ? CFG_RST : s_reg.cfg[ri];
        if (reg_wr && ri != IDX_NONE) begin
            s_next.cfg[ri] = reg_wdata;
        end

        // Chip shifter drains on each accepted chip
        if (s_reg.cv && tx_chip_ready) begin
            s_next.sh = {s_reg.sh[18:0], 1'b0};
            c = s_reg.cnt - 5'h01;
        end

        // Frame sequencer loads the next symbol once the shifter is empty
        unique case (s_reg.st)
            TX_IDLE: begin
                if (tx_start) begin
                    s_next.st   = TX_PRE;
                    s_next.bcnt = s_reg.cfg[IDX_PL];             // RULE6
                    s_next.pn   = PN_SEED;
                    s_next.crc  = CRC_SEED;
                    s_next.rd   = 1'b0;
                    s_next.last = 1'b0;
                end
            end
            TX_PRE: begin
                if (c == 5'h00) begin
                    if (s_reg.bcnt != 8'h00) begin
                        s_next.sh   = {PRE_PAT, 12'h000};      // RULE6
                        c           = BITS_8;
                        s_next.bcnt = s_reg.bcnt - 8'h01;
                    end else begin
                        s_next.st   = TX_SYNC;
                        s_next.bcnt = {6'h00, nsync};          // RULE10
                    end
                end
            end
            TX_SYNC: begin
                if (c == 5'h00) begin
                    if (s_reg.bcnt != 8'h00) begin
                        s_next.sh   = {sync_pattern[{si, 3'b000} +: 8], 12'h000}; // RULE13
                        c           = BITS_8;
                        s_next.bcnt = s_reg.bcnt - 8'h01;
                    end else begin
                        s_next.st = TX_DATA;
                    end
                end
            end
            TX_DATA: begin
                if (c == 5'h00) begin
                    if (s_reg.last) begin
                        s_next.st   = TX_CRC;
                        s_next.bcnt = CRC_BYTES;
                    end else if (s_reg.rdy && tx_valid) begin
                        enc         = 1'b1;
                        ecrc        = 1'b1;
                        eb          = tx_data;
                        s_next.last = tx_last;
                    end
                end
            end
            TX_CRC: begin
                if (c == 5'h00) begin
                    if (s_reg.bcnt != 8'h00) begin
                        enc         = 1'b1;
                        eb          = (s_reg.bcnt == CRC_BYTES) ? s_reg.crc[15:8] : s_reg.crc[7:0];
                        s_next.bcnt = s_reg.bcnt - 8'h01;
                    end else begin
                        s_next.st = TX_IDLE;
                    end
                end
            end
            default: s_next.st = TX_IDLE;
        endcase

        // Payload symbol: checksum over the plain byte, whiten, balance, then split-phase
        if (enc) begin
            pm        = pn8(s_reg.pn);
            s_next.pn = pm[16:8];
            w         = wht ? (eb ^ pm[7:0]) : eb;               // RULE4
            if (ecrc) begin
                s_next.crc = crc8(s_reg.crc, eb, poly);        // RULE7
            end
            wp = pop24({16'h0000, w});
            if (!dcb) begin
                code = {w, 2'b00};
            end else if (wp == 5'h04) begin
                code = {w, FLAG_PLAIN};
            end else begin
                // Invert when the byte would push disparity further the same way
                code      = ((wp > 5'h04) == s_reg.rd) ? {~w, FLAG_INV} : {w, FLAG_PLAIN}; // RULE3
                s_next.rd = ~s_reg.rd;
            end
            s_next.sh = man ? man_exp(code) : {code, 10'h000};  // RULE2
            c         = need;
        end
        s_next.cnt = c;
        s_next.cv  = c != 5'h00;
        s_next.rdy = s_next.st == TX_DATA && c == 5'h00 && !s_next.last;

        // Receiver: hunt for preamble and sync, then collect symbols
        s_next.sf   = 1'b0;
        s_next.rval = 1'b0;
        if (!rx_enable) begin
            s_next.insync = 1'b0;
            s_next.pre    = 1'b0;
        end else if (rx_chip_valid) begin
            s_next.win = rw;
            if (!s_reg.insync) begin
                if (pre_ok) begin
                    s_next.pre = 1'b1;                          // RULE1
                end
                if ((thr == 4'h0 || s_reg.pre || pre_ok) &&
                    pop24(mask & (rw ^ sw)) <= {3'h0, tol}) begin // RULE8
                    s_next.insync = 1'b1;
                    s_next.sf     = 1'b1;
                    s_next.pre    = 1'b0;
                    s_next.rpn    = PN_SEED;
                    s_next.rcrc   = CRC_SEED;
                    s_next.rcnt   = 5'h00;
                end
            end else begin
                s_next.rsh = {s_reg.rsh[18:0], rx_chip};
                if (s_reg.rcnt + 5'h01 == need) begin
                    v     = s_next.rsh << (CHIPS_MAX - need);
                    rcode = man ? man_dec(v) : v[19:10];        // RULE2
                    rw8   = (dcb && rcode[1:0] == FLAG_INV) ? ~rcode[9:2] : rcode[9:2]; // RULE3
                    pm2   = pn8(s_reg.rpn);
                    rb    = wht ? (rw8 ^ pm2[7:0]) : rw8;        // RULE4
                    s_next.rpn  = pm2[16:8];
                    s_next.rcrc = crc8(s_reg.rcrc, rb, poly);   // RULE7
                    s_next.rdat = rb;
                    s_next.rval = 1'b1;
                    s_next.rcnt = 5'h00;
                end else begin
                    s_next.rcnt = s_reg.rcnt + 5'h01;
                end
            end
        end
        // Zero residue means the bytes so far end in a good checksum
        s_next.cok = s_next.insync && s_next.rcrc == 16'h0000;

        // Amplifier enables steered to one pin pair
        s_next.pins = sel ? {2'b00, s_next.st != TX_IDLE, rx_enable} :
                            {s_next.st != TX_IDLE, rx_enable, 2'b00}; // RULE12
    end

    // State register
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            s_reg <= RPF_RST;
        end else begin
            s_reg <= s_next;
        end
    end

    // Outputs straight from the state register
    assign reg_rdata     = s_reg.rdata;
    assign tx_ready      = s_reg.rdy;
    assign tx_chip       = s_reg.sh[19];
    assign tx_chip_valid = s_reg.cv;
    assign rx_data       = s_reg.rdat;
    assign rx_data_valid = s_reg.rval;
    assign preamble_seen = s_reg.pre;
    assign sync_seen     = s_reg.sf;
    assign crc_ok        = s_reg.cok;
    assign pa_ctl_pin_a  = s_reg.pins[3];
    assign lna_ctl_pin_a = s_reg.pins[2];
    assign pa_ctl_pin_b  = s_reg.pins[1];
    assign lna_ctl_pin_b = s_reg.pins[0];
endmodule : rpf_framer

// [rtl/rpf_pkg.sv]
package rpf_pkg;
// Summary of operation
// [RULE1] Preamble threshold 12 allows no pair errors, 11..8 allow one to four; 0 disables.
// [RULE2] Split-phase bit on: Manchester encode transmit chips and decode receive chips.
// [RULE3] DC-balanced bit on: ten-bit balanced code on transmit, decoded on receive.
// [RULE4] Scrambling bit on: whiten transmitted bytes and dewhiten received bytes.
// [RULE5] Symbol width 0 gives 8-bit symbols, 1 gives 10-bit symbols; 2..7 reserved.
// [RULE6] Transmitted preamble length in bytes equals the preamble byte count setting.
// [RULE7] CRC uses the 16-bit value from low and high bytes when custom CRC is on.
// [RULE8] Sync match accepted with up to the 2-bit tolerance of mismatched bits.
// [RULE9] Sync length field sets compared bits, 0 up to at most 24.
// [RULE10] Sync pattern always goes out as whole bytes.
// [RULE11] Host pads unused sync pattern bits with preamble pattern for odd lengths.
// [RULE12] Pin select clear drives first amplifier pin pair, set drives alternate pair.
// [RULE13] Sync sent MSB first from lowest needed byte, only bytes the length needs.
// [RULE14] Software writes zero to reserved bits and avoids reserved encodings.

    // Register offsets and storage indices
    localparam logic [8:0] ADDR_PQ  = 9'h11b;
    localparam logic [8:0] ADDR_SC  = 9'h11c;
    localparam logic [8:0] ADDR_PL  = 9'h11d;
    localparam logic [8:0] ADDR_CL  = 9'h11e;
    localparam logic [8:0] ADDR_CH  = 9'h11f;
    localparam logic [8:0] ADDR_SW  = 9'h120;
    localparam logic [2:0] IDX_PQ   = 3'h0;
    localparam logic [2:0] IDX_SC   = 3'h1;
    localparam logic [2:0] IDX_PL   = 3'h2;
    localparam logic [2:0] IDX_CL   = 3'h3;
    localparam logic [2:0] IDX_CH   = 3'h4;
    localparam logic [2:0] IDX_SW   = 3'h5;
    localparam logic [2:0] IDX_NONE = 3'h7;
    localparam logic [7:0] CFG_RST  = 8'h00;

    // Field positions
    localparam int PIN_SEL = 7;
    localparam int MAN_ON  = 6;
    localparam int CRC_ON  = 5;
    localparam int DCB_ON  = 4;
    localparam int WHT_ON  = 3;
    localparam int THR_MSB = 3;
    localparam int SYM_MSB = 2;
    localparam int TOL_MSB = 7;
    localparam int TOL_LSB = 6;
    localparam int LEN_MSB = 4;

    // Coding constants
    localparam logic [7:0]  PRE_PAT    = 8'h55;
    localparam logic [8:0]  PN_SEED    = 9'h1ff;
    localparam logic [15:0] CRC_SEED   = 16'hffff;
    localparam logic [15:0] CRC_DEF    = 16'h1021;
    localparam logic [4:0]  SYNC_MAX   = 5'h18;
    localparam logic [3:0]  PAIRS      = 4'hc;
    localparam logic [2:0]  SYM_10     = 3'h1;
    localparam logic [4:0]  BITS_8     = 5'h08;
    localparam logic [4:0]  BITS_10    = 5'h0a;
    localparam logic [4:0]  CHIPS_MAX  = 5'h14;
    localparam logic [1:0]  FLAG_PLAIN = 2'h1;
    localparam logic [1:0]  FLAG_INV   = 2'h2;
    localparam logic [7:0]  CRC_BYTES  = 8'h02;

    typedef enum logic [2:0] {
        TX_IDLE = 3'b000,
        TX_PRE  = 3'b001,
        TX_SYNC = 3'b011,
        TX_DATA = 3'b010,
        TX_CRC  = 3'b110
    } rpf_tx_type;

    typedef struct packed {
        logic [5:0][7:0] cfg;
        logic [7:0]      rdata;
        rpf_tx_type      st;
        logic [19:0]     sh;
        logic [4:0]      cnt;
        logic [7:0]      bcnt;
        logic [8:0]      pn;
        logic [15:0]     crc;
        logic            rd;
        logic            last;
        logic            cv;
        logic            rdy;
        logic [23:0]     win;
        logic            pre;
        logic            insync;
        logic            sf;
        logic            rval;
        logic            cok;
        logic [19:0]     rsh;
        logic [4:0]      rcnt;
        logic [8:0]      rpn;
        logic [15:0]     rcrc;
        logic [7:0]      rdat;
        logic [3:0]      pins;
    } rpf_state_type;

    localparam rpf_state_type RPF_RST = '0;
endpackage : rpf_pkg

// [dv/rpf_framer_properties.sv]
`timescale 1ns/1ps
module rpf_framer_checker (
    input wire logic       sys_clk,
    input wire logic       rst_b,
    input wire logic [8:0] reg_addr,
    input wire logic       reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic       tx_chip,
    input wire logic       tx_chip_valid,
    input wire logic       tx_chip_ready,
    input wire logic       rx_enable,
    input wire logic       rx_chip_valid,
    input wire logic       rx_data_valid,
    input wire logic       preamble_seen,
    input wire logic       sync_seen,
    input wire logic       pa_ctl_pin_a,
    input wire logic       lna_ctl_pin_a,
    input wire logic       pa_ctl_pin_b,
    input wire logic       lna_ctl_pin_b
);
    import rpf_pkg::*;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    // Port, pins, pacing
    a_count_readback: assert property ((reg_wr && reg_addr == ADDR_PL) ##1 (!reg_wr && reg_addr == ADDR_PL)
        |=> reg_rdata == $past(reg_wdata, 2)) else $error("readback wrong");
    a_pins_one_pair: assert property (!(pa_ctl_pin_a && pa_ctl_pin_b) && !(lna_ctl_pin_a && lna_ctl_pin_b))
        else $error("two pin pairs on");
    a_lna_follows_on: assert property (rx_enable [*3] |-> (lna_ctl_pin_a || lna_ctl_pin_b))
        else $error("lna off in receive");
    a_lna_follows_off: assert property (!rx_enable [*2] |-> !(lna_ctl_pin_a || lna_ctl_pin_b))
        else $error("lna on when idle");
    a_pa_while_sending: assert property (tx_chip_valid ##1 tx_chip_valid |-> (pa_ctl_pin_a || pa_ctl_pin_b))
        else $error("pa off in send");
    a_chip_held: assert property (tx_chip_valid && !tx_chip_ready |=> tx_chip_valid && $stable(tx_chip))
        else $error("chip dropped");
    a_sync_single: assert property (sync_seen |=> !sync_seen)
        else $error("sync pulse long");
    a_sync_on_chip: assert property (sync_seen |-> $past(rx_chip_valid && rx_enable))
        else $error("sync without chip");
    a_byte_spacing: assert property (rx_data_valid |=> !rx_data_valid [*7])
        else $error("bytes too close");
    a_preamble_clear: assert property (!rx_enable |=> !preamble_seen)
        else $error("preamble kept");

    // Main traffic seen
    c_sync: cover property (sync_seen);
    c_stall: cover property (tx_chip_valid && !tx_chip_ready);
    c_pair_b: cover property (pa_ctl_pin_b || lna_ctl_pin_b);
endmodule : rpf_framer_checker

bind rpf_framer rpf_framer_checker i_checker (.*);

// [dv/rpf_remote_peer.sv]
`timescale 1ns/1ps
module rpf_remote_peer (
    input  wire logic        sys_clk,
    input  wire logic        slow,
    input  wire logic        clr,
    input  wire logic        tx_chip,
    input  wire logic        tx_chip_valid,
    output logic             tx_chip_ready,
    output logic [255:0]     heard,
    output logic [8:0]       heard_n,
    input  wire logic        send_go,
    input  wire logic [63:0] send_vec,
    input  wire logic [6:0]  send_len,
    output logic             send_busy,
    output logic             rx_chip,
    output logic             rx_chip_valid
);
    logic [63:0] sv = '0;
    logic [6:0]  left = '0;
    logic        pace = 1'b0;
    initial begin
        heard = '0;
        heard_n = '0;
        rx_chip = 1'b0;
        rx_chip_valid = 1'b0;
    end
    // Stall every other cycle when slow
    assign tx_chip_ready = !slow || pace;
    assign send_busy     = send_go || left != 7'd0;
    // Log and replay chips
    always @(posedge sys_clk) begin
        pace <= ~pace;
        if (clr) begin
            heard_n <= '0;
        end else if (tx_chip_valid && tx_chip_ready) begin
            heard   <= {heard[254:0], tx_chip};
            heard_n <= heard_n + 9'd1;
        end
        if (send_go && left == 7'd0) begin
            sv   <= send_vec;
            left <= send_len;
        end else if (left != 7'd0) begin
            rx_chip       <= sv[left - 7'd1];
            rx_chip_valid <= 1'b1;
            left          <= left - 7'd1;
        end else begin
            rx_chip       <= ~rx_chip;  // Idle line toggles
            rx_chip_valid <= 1'b0;
        end
    end
endmodule : rpf_remote_peer

// [dv/test_radio_packet_framing_config.sv]
`timescale 1ns/1ps
module test_radio_packet_framing_config;
    import rpf_pkg::*;
    logic         sys_clk = 1'b0;
    logic         rst_b = 1'b0;
    logic [8:0]   reg_addr = '0;
    logic         reg_wr = 1'b0;
    logic [7:0]   reg_wdata = '0;
    logic [23:0]  sync_pattern = 24'h3c5a00;
    logic         tx_start = 1'b0;
    logic         tx_valid = 1'b0;
    logic         rx_enable = 1'b0;
    logic         slow = 1'b0;
    logic         clr = 1'b0;
    logic         send_go = 1'b0;
    logic [63:0]  send_vec = '0;
    logic [6:0]   send_len = '0;
    logic [7:0]   reg_rdata, rx_data, got;
    logic         tx_ready, tx_chip, tx_chip_valid, tx_chip_ready, rx_chip, rx_chip_valid, send_busy;
    logic         rx_data_valid, preamble_seen, sync_seen, crc_ok, pa_a, lna_a, pa_b, lna_b;
    logic [255:0] heard;
    logic [8:0]   heard_n;
    int           failures = 0, tests_run = 0, sync_hits = 0, byte_hits = 0, cycles = 0;

    rpf_framer i_dut (.sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .sync_pattern(sync_pattern), .tx_start(tx_start),
        .tx_data(8'ha5), .tx_valid(tx_valid), .tx_last(1'b1), .tx_ready(tx_ready), .tx_chip(tx_chip),
        .tx_chip_valid(tx_chip_valid), .tx_chip_ready(tx_chip_ready), .rx_enable(rx_enable), .rx_chip(rx_chip),
        .rx_chip_valid(rx_chip_valid), .rx_data(rx_data), .rx_data_valid(rx_data_valid),
        .preamble_seen(preamble_seen), .sync_seen(sync_seen), .crc_ok(crc_ok), .pa_ctl_pin_a(pa_a),
        .lna_ctl_pin_a(lna_a), .pa_ctl_pin_b(pa_b), .lna_ctl_pin_b(lna_b));
    rpf_remote_peer i_peer (.sys_clk(sys_clk), .slow(slow), .clr(clr), .tx_chip(tx_chip),
        .tx_chip_valid(tx_chip_valid), .tx_chip_ready(tx_chip_ready), .heard(heard), .heard_n(heard_n),
        .send_go(send_go), .send_vec(send_vec), .send_len(send_len), .send_busy(send_busy),
        .rx_chip(rx_chip), .rx_chip_valid(rx_chip_valid));

    always #4 sys_clk = ~sys_clk;
    // Pulse counts and timeout
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (sync_seen === 1'b1) sync_hits <= sync_hits + 1;
        if (rx_data_valid === 1'b1) byte_hits <= byte_hits + 1;
        if (rx_data_valid === 1'b1 && byte_hits == 0) got <= rx_data;
        if (cycles == 20000) begin
            failures++;
            tally_and_finish();
        end
    end

    task automatic check_val(input string what, input logic [31:0] exp, input logic [31:0] seen);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check_val

    // Seed ffff, MSB first, no final inversion
    function automatic logic [15:0] crc_of(input logic [15:0] poly, input logic [7:0] d);
        logic [15:0] c;
        c = 16'hffff;
        for (int i = 7; i >= 0; i--) c = (c[15] ^ d[i]) ? ((c << 1) ^ poly) : (c << 1);
        return c;
    endfunction : crc_of

    task automatic put_reg(input logic [8:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge sys_clk);
        reg_wr = 1'b0;
    endtask : put_reg

    task automatic get_reg(input logic [8:0] a, output logic [7:0] v);
        @(negedge sys_clk);
        reg_addr = a;
        @(negedge sys_clk);
        v = reg_rdata;
    endtask : get_reg

    // Reset values, readback, unmapped places
    task automatic reg_case;
        logic [7:0] v;
        for (int i = 0; i < 6; i++) begin
            get_reg(ADDR_PQ + 9'(i), v);
            check_val("reset", 8'h00, v);
            put_reg(ADDR_PQ + 9'(i), {i[3:0], 4'h8});
            get_reg(ADDR_PQ + 9'(i), v);
            check_val("readback", {i[3:0], 4'h8}, v);
        end
        put_reg(9'h11a, 8'hff);
        put_reg(9'h121, 8'hff);
        get_reg(9'h121, v);
        check_val("unmapped", 8'h00, v);
        get_reg(ADDR_SW, v);
        check_val("sync kept", 8'h58, v);
    endtask : reg_case

    // One frame out
    task automatic tx_case(input logic [7:0] pq, input logic [7:0] sc, input logic [15:0] pay, input int w,
                           input logic sl);
        logic [15:0] c, pg;
        int n;
        c = crc_of(sc[CRC_ON] ? 16'h8005 : CRC_DEF, 8'ha5);
        put_reg(ADDR_PQ, pq);
        put_reg(ADDR_SC, sc);
        @(negedge sys_clk);
        clr = 1'b1;
        slow = sl;
        tx_start = 1'b1;
        tx_valid = 1'b1;
        @(negedge sys_clk);
        clr = 1'b0;
        tx_start = 1'b0;
        for (int k = 0; k < 400 && tx_ready !== 1'b1; k++) @(negedge sys_clk);
        @(negedge sys_clk);
        tx_valid = 1'b0;
        for (int k = 0; k < 800 && (pa_a | pa_b) !== 1'b0; k++) @(negedge sys_clk);
        n = heard_n;
        pg = 16'(heard >> (n - 32 - w)) & 16'((32'h1 << w) - 1);
        check_val("header", 32'h55555a3c, heard[n-1 -: 32]);
        if (pay === 16'hffff) check_val("whitened", 1, pg !== 16'h00a5);
        else check_val("payload", pay, pg);
        if ((sc & 8'h5f) == 8'h00) check_val("crc chips", c, heard[15:0]);
        if ((sc & 8'h5f) == 8'h00) check_val("frame chips", 56, n);
    endtask : tx_case

    // One frame in
    task automatic rx_case(input logic [7:0] pq, input logic [7:0] sw, input logic [23:0] pre,
                           input logic [7:0] sy, input logic hit);
        put_reg(ADDR_PQ, pq);
        put_reg(ADDR_SW, sw);
        put_reg(ADDR_SC, 8'h00);
        @(negedge sys_clk);
        sync_hits = 0;
        byte_hits = 0;
        rx_enable = 1'b1;
        send_vec = {8'h00, pre, sy, 8'ha5, crc_of(CRC_DEF, 8'ha5)};
        send_len = 7'd56;
        send_go = 1'b1;
        @(negedge sys_clk);
        send_go = 1'b0;
        for (int k = 0; k < 100 && send_busy; k++) @(negedge sys_clk);
        repeat (3) @(negedge sys_clk);
        check_val("syncs", {31'h0, hit}, sync_hits);
        check_val("bytes", hit ? 3 : 0, byte_hits);
        if (hit) check_val("first byte", 8'ha5, got);
        check_val("crc good", {31'h0, hit}, {31'h0, crc_ok});
        rx_enable = 1'b0;
    endtask : rx_case

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : tally_and_finish

    // Main sequence
    initial begin
        repeat (2) @(negedge sys_clk);
        rst_b = 1'b1;
        reg_case();
        put_reg(ADDR_PL, 8'h02);
        put_reg(ADDR_SW, 8'h0c);
        put_reg(ADDR_CL, 8'h05);
        put_reg(ADDR_CH, 8'h80);
        tx_case(8'h0c, 8'h20, 16'h00a5, 8, 1'b1);
        tx_case(8'h0c, 8'h00, 16'h00a5, 8, 1'b0);
        tx_case(8'h0c, 8'h40, 16'h9966, 16, 1'b0);
        tx_case(8'h0c, 8'h01, 16'h0294, 10, 1'b0);
        tx_case(8'h0c, 8'h11, 16'h0295, 10, 1'b0);
        tx_case(8'h8c, 8'h08, 16'hffff, 8, 1'b0);
        rx_case(8'h0a, 8'h08, 24'h545454, 8'h3c, 1'b0);
        rx_case(8'h0c, 8'h0c, 24'h55555a, 8'h3c, 1'b1);
        rx_case(8'h8a, 8'h08, 24'h545455, 8'h3c, 1'b1);
        rx_case(8'h0c, 8'h48, 24'h555555, 8'h3d, 1'b1);
        rx_case(8'h0c, 8'h08, 24'h555555, 8'h3d, 1'b0);
        rx_case(8'h00, 8'h08, 24'h000000, 8'h3c, 1'b1);
        rx_case(8'h0c, 8'h08, 24'h000000, 8'h3c, 1'b0);
        tally_and_finish();
    end
endmodule : test_radio_packet_framing_config
